// [verilog/clock_generator_mode_config.v]
/*
 * Control and status registers of the on-chip clock generator: mode
 * selection, loop multiplier and divider, oscillator options, loss of
 * lock and loss of clock responses, and internal reference trim.
 * Assumes analog status (lock, clock loss, external reference ready,
 * oscillator stable) arrives asynchronously on pins; the bus master
 * follows Avalon-MM with waitrequest on clk_in.
 */
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "clock_generator_regs.vh"

// Notes on behaviour
// - Reset gives self-clocked mode, about 8 MHz
// - Bus clock is half the output clock
// - Internal locked: reference/7 times 64 N over R
// - Range bit: set P=1, clear P=64
// - Mode 11: external locked, ext*P*N/R
// - Mode 01: locked on internal reference
// - Multiplier field sets N; 011 gives 10
// - Divider field: 000 by one, 001 by two
// - Cleared gain bit means low-power oscillator
// - Set reference select requests crystal oscillator in modes 10 and 11
// - Reference select ignored in internal locked mode
// - Cleared stop-enable turns oscillator off in stop
// - Control one bit zero reads zero
// - Lock loss, reset enable clear: interrupt
// - Clock loss, reset enable and LOCD clear: interrupt
// - Status one read-only except flag clear
// - Status two reports oscillator stable, read-only
// - Eight-bit trim adjusts internal reference
// - Mode 00 self-clocked, 10 bypassed external
// - Bypassed external waits for reference status
// - Range bit accepts only first write
// - Lock loss with reset enable set: reset request
module clock_generator_mode_config (
  input wire clk_in,
  input wire rst_n_in,
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire lock_in,
  input wire lock_loss_in,
  input wire clock_loss_in,
  input wire ext_ref_ready_in,
  input wire osc_stable_in,
  input wire stop_mode_in,
  output reg [1:0] active_mode_out,
  output reg [6:0] prescale_out,
  output reg [4:0] multiplier_out,
  output reg [7:0] divisor_out,
  output reg [2:0] ref_divisor_out,
  output reg gain_select_out,
  output reg crystal_request_out,
  output reg osc_enable_out,
  output reg clock_loss_detect_out,
  output reg [7:0] trim_out,
  output reg [15:0] self_clock_khz_out,
  output reg bus_clock_half_out,
  output reg irq_out,
  output reg reset_req_out
);

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function [4:0] mult_n;
    input [2:0] code;
    begin
      mult_n = `CG_N_BASE + {1'b0, code, 1'b0};
    end
  endfunction

  function [7:0] div_r;
    input [2:0] code;
    begin
      div_r = 8'h01 << code;
    end
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {stop_mode_in, osc_stable_in, ext_ref_ready_in,
                  clock_loss_in, lock_loss_in, lock_in};
      sync2_q <= sync1_q;
    end
  end
  wire lock_s = sync2_q[0];
  wire lol_s = sync2_q[1];
  wire loc_s = sync2_q[2];
  wire external_reference_status_s = sync2_q[3];
  wire oscillator_stable_flag_s = sync2_q[4];
  wire stop_s = sync2_q[5];

  // --------------------------------------------------------------------
  // Bus slave: one wait cycle on every access
  // --------------------------------------------------------------------
  // Wait state keeps read data registered without a combinational path
  reg ack_q;
  wire req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  wire take = req & ack_q;
  wire wr = take & avs_write_in & avs_byteenable_in[0];
  wire rd = take & avs_read_in;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  wire [7:0] wbyte = avs_writedata_in[7:0];
  wire wr_c1 = wr && avs_address_in == {1'b0, `CG_OFS_CTRL_ONE};
  wire wr_c2 = wr && avs_address_in == {1'b0, `CG_OFS_CTRL_TWO};
  wire wr_s1 = wr && avs_address_in == {1'b0, `CG_OFS_STAT_ONE};
  wire wr_tr = wr && avs_address_in == `CG_OFS_TRIM;

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [7:0] trim_q;
  reg range_locked_q;
  reg [1:0] mode_q;
  reg if_q;
  reg lols_q;
  reg locs_q;
  reg lol_prev_q;
  reg loc_prev_q;

  wire [1:0] req_mode = ctrl1_q[`CG_C1_MODE_HI:`CG_C1_MODE_LO];

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl1_q <= `CG_C1_RESET;
      ctrl2_q <= `CG_C2_RESET;
      trim_q <= `CG_TRIM_RESET;
      range_locked_q <= 1'b0;
    end else begin
      if (wr_c1) begin
        ctrl1_q[`CG_C1_GAIN] <= wbyte[`CG_C1_GAIN];
        ctrl1_q[`CG_C1_EXTERNAL_REFERENCE_SELECT] <= wbyte[`CG_C1_EXTERNAL_REFERENCE_SELECT];
        ctrl1_q[`CG_C1_MODE_HI:`CG_C1_MODE_LO] <=
          wbyte[`CG_C1_MODE_HI:`CG_C1_MODE_LO];
        ctrl1_q[`CG_C1_OSC_IN_STOP_ENABLE] <= wbyte[`CG_C1_OSC_IN_STOP_ENABLE];
        ctrl1_q[`CG_C1_LOCD] <= wbyte[`CG_C1_LOCD];
        range_locked_q <= 1'b1;
        if (!range_locked_q)
          ctrl1_q[`CG_C1_RANGE] <= wbyte[`CG_C1_RANGE];
      end
      if (wr_c2)
        ctrl2_q <= wbyte;
      if (wr_tr)
        trim_q <= wbyte;
    end
  end

  // --------------------------------------------------------------------
  // Active mode: bypassed external waits for the reference
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      mode_q <= `CG_MODE_SELF;
    else if (req_mode != `CG_MODE_FBE || external_reference_status_s)
      mode_q <= req_mode;
  end

  // --------------------------------------------------------------------
  // Loss events: sticky status, set wins over clear
  // --------------------------------------------------------------------
  wire lol_rise = lol_s & ~lol_prev_q;
  wire loc_rise = loc_s & ~loc_prev_q & ~ctrl1_q[`CG_C1_LOCD];
  wire clr_if = wr_s1 & wbyte[`CG_S1_IF];
  wire lol_irq = lol_rise & ~ctrl2_q[`CG_C2_LOCK_LOSS_RESET_ENABLE];
  wire loc_irq = loc_rise & ~ctrl2_q[`CG_C2_CLOCK_LOSS_RESET_ENABLE];

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lol_prev_q <= 1'b0;
      loc_prev_q <= 1'b0;
      if_q <= 1'b0;
      lols_q <= 1'b0;
      locs_q <= 1'b0;
    end else begin
      lol_prev_q <= lol_s;
      loc_prev_q <= loc_s;
      if (lol_irq || loc_irq)
        if_q <= 1'b1;
      else if (clr_if)
        if_q <= 1'b0;
      if (lol_rise)
        lols_q <= 1'b1;
      else if (clr_if)
        lols_q <= 1'b0;
      if (loc_rise)
        locs_q <= 1'b1;
      else if (clr_if)
        locs_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  wire [7:0] stat1 = {3'h0, lols_q, lock_s, locs_q, external_reference_status_s, if_q};
  wire [7:0] stat2 = {7'h00, oscillator_stable_flag_s};
  reg [7:0] rmux;
  always @* begin
    case (avs_address_in)
      {1'b0, `CG_OFS_CTRL_ONE}: rmux = ctrl1_q & `CG_C1_MASK;
      {1'b0, `CG_OFS_CTRL_TWO}: rmux = ctrl2_q;
      {1'b0, `CG_OFS_STAT_ONE}: rmux = stat1;
      {1'b0, `CG_OFS_STAT_TWO}: rmux = stat2;
      `CG_OFS_TRIM: rmux = trim_q;
      default: rmux = 8'h00;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in & ~ack_q)
      avs_readdata_out <= {24'h000000, rmux};
  end

  // --------------------------------------------------------------------
  // Generator settings driven to the analog core
  // --------------------------------------------------------------------
  wire ext_locked = mode_q == `CG_MODE_FEE;
  wire int_locked = mode_q == `CG_MODE_FEI;
  wire uses_ext = mode_q[1];

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_mode_out <= `CG_MODE_SELF;
      prescale_out <= `CG_P_LOW;
      multiplier_out <= `CG_N_BASE;
      divisor_out <= 8'h01;
      ref_divisor_out <= 3'h1;
      gain_select_out <= 1'b0;
      crystal_request_out <= 1'b0;
      osc_enable_out <= 1'b0;
      clock_loss_detect_out <= 1'b0;
      trim_out <= `CG_TRIM_RESET;
      self_clock_khz_out <= `CG_SELF_KHZ;
      bus_clock_half_out <= 1'b1;
      irq_out <= 1'b0;
      reset_req_out <= 1'b0;
    end else begin
      active_mode_out <= mode_q;
      // Internal reference always uses P of 64 and divide by seven
      if (int_locked) begin
        prescale_out <= `CG_P_LOW;
        ref_divisor_out <= `CG_IRG_DIV;
      end else begin
        prescale_out <= ctrl1_q[`CG_C1_RANGE] ? `CG_P_HIGH
                                              : `CG_P_LOW;
        ref_divisor_out <= 3'h1;
      end
      multiplier_out <= mult_n(ctrl2_q[`CG_C2_MFD_HI:`CG_C2_MFD_LO]);
      divisor_out <= div_r(ctrl2_q[`CG_C2_RFD_HI:`CG_C2_RFD_LO]);
      gain_select_out <= ctrl1_q[`CG_C1_GAIN];
      crystal_request_out <= uses_ext & ctrl1_q[`CG_C1_EXTERNAL_REFERENCE_SELECT];
      osc_enable_out <= uses_ext &
                        (~stop_s | ctrl1_q[`CG_C1_OSC_IN_STOP_ENABLE]);
      clock_loss_detect_out <= ~ctrl1_q[`CG_C1_LOCD] & ext_locked;
      trim_out <= trim_q;
      self_clock_khz_out <= `CG_SELF_KHZ;
      bus_clock_half_out <= 1'b1;
      irq_out <= if_q;
      reset_req_out <= (lol_rise & ctrl2_q[`CG_C2_LOCK_LOSS_RESET_ENABLE]) |
                       (loc_rise & ctrl2_q[`CG_C2_CLOCK_LOSS_RESET_ENABLE]);
    end
  end

endmodule

// [verilog/clock_generator_regs.vh]
/*
 * Register offsets, field positions, reset values and encodings of the
 * clock generator control block.
 * Assumes an Avalon-MM slave with 32-bit data and byte addresses.
 */
`ifndef CLOCK_GENERATOR_REGS_VH
`define CLOCK_GENERATOR_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CG_ADDR_W 4
`define CG_OFS_CTRL_ONE 4'h0
`define CG_OFS_CTRL_TWO 4'h4
`define CG_OFS_STAT_ONE 4'h8
`define CG_OFS_STAT_TWO 4'hc

// Trim lives on its own five-bit address 5'h10 beyond the four above
`define CG_ADDR_TRIM_W 5
`define CG_OFS_TRIM 5'h10
`define CG_OFS_EVENT 5'h14

// ----------------------------------------------------------------------
// Control register one fields
// ----------------------------------------------------------------------
`define CG_C1_GAIN 7
`define CG_C1_RANGE 6
`define CG_C1_EXTERNAL_REFERENCE_SELECT 5
`define CG_C1_MODE_HI 4
`define CG_C1_MODE_LO 3
`define CG_C1_OSC_IN_STOP_ENABLE 2
`define CG_C1_LOCD 1
`define CG_C1_RESET 8'h00
`define CG_C1_MASK 8'hfe

// ----------------------------------------------------------------------
// Control register two fields
// ----------------------------------------------------------------------
`define CG_C2_LOCK_LOSS_RESET_ENABLE 7
`define CG_C2_MFD_HI 6
`define CG_C2_MFD_LO 4
`define CG_C2_CLOCK_LOSS_RESET_ENABLE 3
`define CG_C2_RFD_HI 2
`define CG_C2_RFD_LO 0
`define CG_C2_RESET 8'h00

// ----------------------------------------------------------------------
// Status register one and two fields
// ----------------------------------------------------------------------
`define CG_S1_LOLS 4
`define CG_S1_LOCK 3
`define CG_S1_LOCS 2
`define CG_S1_EXTERNAL_REFERENCE_STATUS 1
`define CG_S1_IF 0
`define CG_S2_OSCILLATOR_STABLE_FLAG 0

`define CG_TRIM_RESET 8'h80

// ----------------------------------------------------------------------
// Clock mode codes
// ----------------------------------------------------------------------
`define CG_MODE_SELF 2'h0
`define CG_MODE_FEI 2'h1
`define CG_MODE_FBE 2'h2
`define CG_MODE_FEE 2'h3

// ----------------------------------------------------------------------
// Prescale, reference divisor, multiplier decode
// ----------------------------------------------------------------------
`define CG_P_LOW 7'h40
`define CG_P_HIGH 7'h01
`define CG_IRG_DIV 3'h7
`define CG_N_BASE 5'h04
`define CG_SELF_KHZ 16'h1f40

`endif

// [sim/clock_generator_monitor.sv]
/* Concurrent checks on the ports of the clock generator control block.
   Assumes it is bound to the top module and that a master keeps at
   least three edges between two accepted control writes. */
`timescale 1ns/10ps
module clock_generator_monitor (
  input wire clk_in,
  input wire rst_n_in,
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [1:0] active_mode_out,
  input wire [6:0] prescale_out,
  input wire [4:0] multiplier_out,
  input wire [7:0] divisor_out,
  input wire [2:0] ref_divisor_out,
  input wire [15:0] self_clock_khz_out,
  input wire bus_clock_half_out,
  input wire reset_req_out
);
  wire req = avs_read_in | avs_write_in;
  wire acc = req & !avs_waitrequest_out;
  wire wr_ok = acc & avs_write_in & avs_byteenable_in[0];
  wire w1 = wr_ok & (avs_address_in == 5'h00);
  wire w2 = wr_ok & (avs_address_in == 5'h04);
  wire [7:0] d = avs_writedata_in[7:0];
  reg done_q;
  reg rng_q;
  reg [7:0] dq;
  // ------------------------------------------------------------
  // Helper state: last control data and first-write marker
  // ------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_q <= 1'b0;
      rng_q <= 1'b0;
      dq <= 8'h00;
    end else begin
      if (w1) begin
        done_q <= 1'b1;
      end
      if (w1 & !done_q) begin
        rng_q <= d[6];
      end
      if (w1 | w2) begin
        dq <= d;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_wait; req && !$past(req) |-> avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("no wait cycle");
  property p_one; req && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_one: assert property (p_one) else $error("wait longer than one");
  property p_b0; acc && avs_read_in && avs_address_in == 5'h00
    |-> avs_readdata_out[0] == 1'b0 && avs_readdata_out[31:8] == 24'h0;
  endproperty
  a_b0: assert property (p_b0) else $error("ctrl one bit 0 set");
  property p_mode; w1 && d[4:3] != 2'h2 |-> ##3 active_mode_out == dq[4:3];
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_ref; w1 && d[4:3] == 2'h1 |-> ##3 ref_divisor_out == 3'h7;
  endproperty
  a_ref: assert property (p_ref) else $error("ref divisor wrong");
  property p_mul; w2 |-> ##2 multiplier_out == 5'h04 + {dq[6:4], 1'b0}
    && divisor_out == 8'h01 << dq[2:0];
  endproperty
  a_mul: assert property (p_mul) else $error("N or R wrong");
  property p_rng; w1 && !done_q
    |-> ##2 prescale_out == (dq[6] ? 7'h01 : 7'h40);
  endproperty
  a_rng: assert property (p_rng) else $error("prescale wrong");
  // Internal locked mode forces P to 64, so only other modes show range
  property p_once; w1 && done_q |-> ##3 (active_mode_out == 2'h1 ||
    prescale_out == (rng_q ? 7'h01 : 7'h40));
  endproperty
  a_once: assert property (p_once) else $error("range rewritten");
  property p_pulse; reset_req_out |=> !reset_req_out; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse long");
  property p_const; bus_clock_half_out && self_clock_khz_out == 16'h1f40;
  endproperty
  a_const: assert property (p_const) else $error("clock consts");
endmodule

// [sim/clock_generator_mode_config_tb.sv]
/* Self-checking bench for the clock generator control block.
   Assumes the design header is on the include path. */
`timescale 1ns/10ps
module clock_generator_mode_config_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [4:0] adr = 5'h00;
  reg re = 1'b0;
  reg we = 1'b0;
  reg [31:0] wd = 32'h0;
  reg ll = 1'b0, cl = 1'b0, er = 1'b0, os = 1'b0, sm = 1'b0;
  wire [31:0] rd;
  wire wt, gs, cr, oe, cd, bh, irq, rr;
  wire [1:0] md;
  wire [6:0] ps;
  wire [4:0] mu;
  wire [7:0] dv, tr;
  wire [2:0] rf;
  wire [15:0] kz;
  integer errors = 0, total_checks = 0, i;
  reg [7:0] rv;
  always #25 clk = !clk;
  clock_generator_mode_config dut (.clk_in(clk), .rst_n_in(rst_n),
    .avs_address_in(adr), .avs_read_in(re), .avs_write_in(we),
    .avs_writedata_in(wd), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rd), .avs_waitrequest_out(wt), .lock_in(1'b0),
    .lock_loss_in(ll), .clock_loss_in(cl), .ext_ref_ready_in(er),
    .osc_stable_in(os), .stop_mode_in(sm), .active_mode_out(md),
    .prescale_out(ps), .multiplier_out(mu), .divisor_out(dv),
    .ref_divisor_out(rf), .gain_select_out(gs), .crystal_request_out(cr),
    .osc_enable_out(oe), .clock_loss_detect_out(cd), .trim_out(tr),
    .self_clock_khz_out(kz), .bus_clock_half_out(bh), .irq_out(irq),
    .reset_req_out(rr));
  // ------------------------------------------------------------
  // Bus, wait and compare helpers
  // ------------------------------------------------------------
  task summarize;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task xfer(input w, input [4:0] a, input [7:0] dat);
    integer n;
    begin
      @(posedge clk);
      adr <= a;
      wd <= {24'h0, dat};
      we <= w;
      re <= !w;
      n = 0;
      @(posedge clk);
      while (wt !== 1'b0 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      rv = rd[7:0];
      if (n == 20) begin
        errors = errors + 1;
        $display("[ERR] waitrequest exp 0 got 1");
        summarize;
      end
      we <= 1'b0;
      re <= 1'b0;
    end
  endtask
  // Outputs lag a control write by up to two edges, so let four pass
  task st;
    begin
      repeat (4) @(posedge clk);
      @(negedge clk);
    end
  endtask
  task hold(input integer s);
    integer k;
    begin
      k = 0;
      while (k < 30 && !(s == 0 ? irq === 1'b1 : s == 1 ? rr === 1'b1 :
             md === 2'h2)) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 30) begin
        errors = errors + 1;
        $display("[ERR] hold exp event got timeout");
        summarize;
      end
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    st;
    chk("mode", 2'h0, md);
    chk("khz", 16'h1f40, kz);
    chk("half", 1'b1, bh);
    xfer(1'b0, 5'h10, 8'h00);
    chk("trim", 8'h80, rv);
    xfer(1'b1, 5'h00, 8'h79);
    st;
    chk("mode", 2'h3, md);
    chk("prescl", 7'h01, ps);
    chk("xtal", 1'b1, cr);
    chk("gain", 1'b0, gs);
    chk("locd", 1'b1, cd);
    xfer(1'b0, 5'h00, 8'h00);
    chk("ctrl1", 8'h78, rv);
    xfer(1'b1, 5'h00, 8'h08);
    sm <= 1'b1;
    st;
    chk("mode", 2'h1, md);
    chk("prescl", 7'h40, ps);
    chk("refdiv", 3'h7, rf);
    chk("osc_en", 1'b0, oe);
    @(posedge clk);
    sm <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      xfer(1'b1, 5'h04, {1'b0, i[2:0], 1'b0, i[2:0]});
      st;
      chk("mult", 5'h04 + {i[2:0], 1'b0}, mu);
      chk("div", 8'h01 << i[2:0], dv);
    end
    xfer(1'b1, 5'h00, 8'h10);
    st;
    chk("mode", 2'h1, md);
    @(posedge clk);
    er <= 1'b1;
    hold(2);
    chk("mode", 2'h2, md);
    xfer(1'b1, 5'h00, 8'h00);
    st;
    chk("mode", 2'h0, md);
    chk("prescl", 7'h01, ps);
    xfer(1'b1, 5'h10, 8'h3c);
    st;
    chk("trim", 8'h3c, tr);
    xfer(1'b0, 5'h10, 8'h00);
    chk("trim", 8'h3c, rv);
    os <= 1'b1;
    xfer(1'b1, 5'h0c, 8'h00);
    xfer(1'b0, 5'h0c, 8'h00);
    chk("stat2", 8'h01, rv);
    xfer(1'b1, 5'h18, 8'hff);
    xfer(1'b0, 5'h18, 8'h00);
    chk("unmap", 8'h00, rv);
    ll <= 1'b1;
    hold(0);
    chk("irq", 1'b1, irq);
    ll <= 1'b0;
    xfer(1'b0, 5'h08, 8'h00);
    chk("flag", 1'b1, rv[0]);
    xfer(1'b1, 5'h08, 8'h01);
    st;
    chk("irq", 1'b0, irq);
    @(posedge clk);
    cl <= 1'b1;
    hold(0);
    chk("irq", 1'b1, irq);
    cl <= 1'b0;
    xfer(1'b1, 5'h08, 8'h01);
    xfer(1'b1, 5'h04, 8'h80);
    ll <= 1'b1;
    hold(1);
    chk("rstreq", 1'b1, rr);
    chk("irq", 1'b0, irq);
    ll <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    st;
    chk("prescl", 7'h40, ps);
    xfer(1'b1, 5'h00, 8'h40);
    st;
    chk("prescl", 7'h01, ps);
    summarize;
  end
endmodule
bind clock_generator_mode_config clock_generator_monitor mon (.clk_in,
  .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .active_mode_out, .prescale_out, .multiplier_out,
  .divisor_out, .ref_divisor_out, .self_clock_khz_out, .bus_clock_half_out,
  .reset_req_out);
